/* logic/bsx_pkg.sv */
// bsx_pkg: constants and types for the bit-serial eeprom host controller
// assumes a 25 MHz mclk; all strobe timing is counted in mclk cycles
package bsx_pkg;
  localparam int unsigned CLK_PERIOD_NS  = 40;
  localparam int unsigned STROBE_NS      = 80;   // least low time of a strobe
  localparam int unsigned STROBE_CYC     = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ADDR_BITS      = 16;
  localparam int unsigned BYTE_BITS      = 8;
  localparam logic [15:0] ADDR_TOP       = 16'hffff;
  localparam logic [15:0] ADDR_WRAP      = 16'h0000;
  localparam logic [15:0] CTRL_ADDR      = 16'hffff;
  localparam int unsigned GUARD_BIT_POS  = 7;    // guard_pin_honor_bit position
  localparam logic [3:0]  CNT_RESET      = 4'h0;
  localparam logic [7:0]  DATA_RESET     = 8'h00;

  // command codes presented on the user port
  typedef enum logic [1:0] {
    BSX_CMD_READ   = 2'h0,   // addressed read of one or more bytes
    BSX_CMD_WRITE  = 2'h1,   // page load then start nonvolatile write
    BSX_CMD_POLL   = 2'h2,   // single status read of the data line
    BSX_CMD_RESET  = 2'h3    // read / write-0 / read triple only
  } bsx_cmd_t;

  // one bus cycle kind on the pins
  typedef enum logic [1:0] {
    BSX_CYC_RD  = 2'h0,
    BSX_CYC_WR  = 2'h1,
    BSX_CYC_IDL = 2'h2
  } bsx_cyc_t;
endpackage

/* logic/bsx_cyc_if.sv */
// bsx_cyc_if: request and answer of a single pin bus cycle
// assumes both ends run on mclk
`timescale 1ns/10ps
interface bsx_cyc_if;
  import bsx_pkg::*;
  logic     req;    // pulse: start one cycle
  bsx_cyc_t kind;   // read or write cycle
  logic     wbit;   // bit to write
  logic     done;   // pulse: cycle finished
  logic     rbit;   // sampled bit on a read
  modport seq (output req, output kind, output wbit, input done, input rbit);
  modport eng (input req, input kind, input wbit, output done, output rbit);
endinterface

/* logic/bsx_cycle.sv */
// bsx_cycle: runs one chip-selected bus cycle on the eeprom pins
// assumes sio_in already passed two flip-flops upstream
`timescale 1ns/10ps
module bsx_cycle
  import bsx_pkg::*;
#(
  parameter int unsigned STROBE = STROBE_CYC
)(
  input  wire logic mclk,
  input  wire logic reset_n,
  bsx_cyc_if.eng    cyc,
  input  wire logic sio_sync,
  output logic      ce_n,
  output logic      oe_n,
  output logic      we_n,
  output logic      sio_out,
  output logic      sio_oe_n
);
  import bsx_pkg::*;

  // the read sample needs the strobe to outlast the two-flop pin path
  if (STROBE < 2 || STROBE > 15)
  begin : g_bad_strobe
    $error("bsx_cycle: STROBE out of range");
  end

  typedef enum logic [1:0] {BSX_C_IDLE, BSX_C_LOW, BSX_C_HOLD} bsx_cst_t;
  bsx_cst_t   st, next_st;
  logic [3:0] cnt, next_cnt;
  logic       next_ce_n, next_oe_n, next_we_n, next_sio_out, next_sio_oe_n;
  logic       next_done, next_rbit;

  // strobe sequencer; ce rises together with we so data is latched there
  always_comb
  begin
    next_st       = st;
    next_cnt      = cnt;
    next_ce_n     = ce_n;
    next_oe_n     = oe_n;
    next_we_n     = we_n;
    next_sio_out  = sio_out;
    next_sio_oe_n = sio_oe_n;
    next_done     = 1'b0;
    next_rbit     = cyc.rbit;
    unique case (st)
      BSX_C_IDLE:
        if (cyc.req)
        begin
          next_st   = BSX_C_LOW;
          next_cnt  = CNT_RESET;
          next_ce_n = 1'b0;
          if (cyc.kind == BSX_CYC_WR)
          begin
            next_we_n     = 1'b0;
            next_oe_n     = 1'b1;
            next_sio_out  = cyc.wbit;
            next_sio_oe_n = 1'b0;
          end
          else
          begin
            next_oe_n     = 1'b0;
            next_we_n     = 1'b1;
            next_sio_oe_n = 1'b1;
          end
        end
      BSX_C_LOW:
        if (cnt == 4'(STROBE - 1))
        begin
          next_st   = BSX_C_HOLD;
          next_ce_n = 1'b1;
          next_we_n = 1'b1;
          next_oe_n = 1'b1;
        end
        else
          next_cnt = cnt + 4'h1;
      BSX_C_HOLD:
      begin
        next_st       = BSX_C_IDLE;           // data held one cycle past the edge
        next_sio_oe_n = 1'b1;
        next_done     = 1'b1;
        // synchroniser output now shows the pin as it stood at the last strobe-low edge
        next_rbit     = sio_sync;
      end
    endcase
  end

  // registers of the cycle engine
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      st       <= BSX_C_IDLE;
      cnt      <= CNT_RESET;
      ce_n     <= 1'b1;
      oe_n     <= 1'b1;
      we_n     <= 1'b1;
      sio_out  <= 1'b0;
      sio_oe_n <= 1'b1;
      cyc.done <= 1'b0;
      cyc.rbit <= 1'b0;
    end
    else
    begin
      st       <= next_st;
      cnt      <= next_cnt;
      ce_n     <= next_ce_n;
      oe_n     <= next_oe_n;
      we_n     <= next_we_n;
      sio_out  <= next_sio_out;
      sio_oe_n <= next_sio_oe_n;
      cyc.done <= next_done;
      cyc.rbit <= next_rbit;
    end
  end
endmodule // bsx_cycle

/* logic/bsx_host.sv */
// bsx_host: host controller for a bit-serial bus eeprom
// assumes a 25 MHz mclk, synchronous active-low reset, eeprom pins on sio/ce/oe/we
//
// Function
// - host drives write enable low for every bit or command write.
// - host never holds write and output enable low together.
// - read starts with 16 address bits, msb first, no reads between.
// - each byte read through 8 read cycles, write enable high.
// - host issues reset triple before every read and write sequence.
// - page load closed by read, write 1, read to start write.
`timescale 1ns/10ps
module bsx_host
  import bsx_pkg::*;
#(
  parameter int unsigned STROBE = STROBE_CYC
)(
  input  wire logic             mclk,
  input  wire logic             reset_n,
  input  wire logic             cmd_valid,
  input  bsx_pkg::bsx_cmd_t     cmd,
  input  wire logic [15:0]      cmd_addr,
  input  wire logic [5:0]       cmd_len,
  input  wire logic             wr_valid,
  input  wire logic [7:0]       wr_data,
  input  wire logic             guard_pin_n,
  input  wire logic             guard_pin_honor_bit,
  input  wire logic             sio_in,
  output logic                  cmd_ready,
  output logic                  wr_take,
  output logic                  rd_valid,
  output logic [7:0]            rd_data,
  output logic                  busy_nv,
  output logic                  refused,
  output logic                  sio_out,
  output logic                  sio_oe_n,
  output logic                  ce_n,
  output logic                  oe_n,
  output logic                  we_n
);
  import bsx_pkg::*;

  typedef enum logic [3:0] {
    BSX_IDLE, BSX_RST_R1, BSX_RST_W0, BSX_RST_R2, BSX_ADDR, BSX_RBYTE,
    BSX_RSTOP, BSX_WBYTE, BSX_GO_R, BSX_GO_W1, BSX_GO_R2, BSX_POLL
  } bsx_st_t;

  bsx_cyc_if cyc ();

  bsx_st_t     st, next_st;
  bsx_cmd_t    op, next_op;
  logic [15:0] sh, next_sh;
  logic [3:0]  bits, next_bits;
  logic [5:0]  left, next_left;
  logic        issued, next_issued;
  logic        next_cmd_ready, next_wr_take, next_rd_valid, next_busy_nv, next_refused;
  logic [7:0]  next_rd_data;
  logic [1:0]  gsync, sio_s;
  logic        ctrl_wr, next_ctrl_wr;

  // two-flop synchronisers for the pins from outside
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      gsync      <= 2'h3;
      sio_s      <= 2'h3;
    end
    else
    begin
      gsync      <= {gsync[0], guard_pin_n};
      sio_s      <= {sio_s[0], sio_in};
    end
  end

  // control register write refused while guarded
  function automatic logic guarded(input logic pin, input logic honor);
    return honor && !pin;
  endfunction

  bsx_cycle #(.STROBE(STROBE)) u_cycle (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .cyc      (cyc.eng),
    .sio_sync (sio_s[1]),
    .ce_n     (ce_n),
    .oe_n     (oe_n),
    .we_n     (we_n),
    .sio_out  (sio_out),
    .sio_oe_n (sio_oe_n)
  );

  // sequence controller: one pin cycle in flight at a time, static between them
  always_comb
  begin
    next_st        = st;
    next_op        = op;
    next_sh        = sh;
    next_bits      = bits;
    next_left      = left;
    next_issued    = issued;
    next_ctrl_wr   = ctrl_wr;
    next_cmd_ready = 1'b0;
    next_wr_take   = 1'b0;
    next_rd_valid  = 1'b0;
    next_rd_data   = rd_data;
    next_busy_nv   = busy_nv;
    next_refused   = 1'b0;
    cyc.req        = 1'b0;
    cyc.kind       = BSX_CYC_IDL;
    cyc.wbit       = 1'b0;
    unique case (st)
      BSX_IDLE:   ;
      BSX_RST_R1, BSX_RST_R2, BSX_RBYTE, BSX_GO_R, BSX_GO_R2, BSX_POLL:
        cyc.kind = BSX_CYC_RD;
      BSX_RST_W0: cyc.kind = BSX_CYC_WR;
      BSX_ADDR, BSX_WBYTE:
      begin
        cyc.kind = BSX_CYC_WR;
        cyc.wbit = sh[15];
      end
      BSX_RSTOP, BSX_GO_W1:
      begin
        cyc.kind = BSX_CYC_WR;
        cyc.wbit = 1'b1;
      end
    endcase
    cyc.req = (st != BSX_IDLE) && !issued;
    if (cyc.req)
      next_issued = 1'b1;
    if (st == BSX_IDLE)
    begin
      next_cmd_ready = 1'b1;
      if (cmd_valid && cmd_ready)
      begin
        next_cmd_ready = 1'b0;
        next_op        = cmd;
        next_sh        = cmd_addr;
        next_left      = cmd_len;
        next_ctrl_wr   = (cmd_addr == CTRL_ADDR);
        next_st        = (cmd == BSX_CMD_POLL) ? BSX_POLL : BSX_RST_R1;
        if (cmd == BSX_CMD_WRITE && cmd_addr == CTRL_ADDR && guarded(gsync[1], guard_pin_honor_bit))
        begin
          next_refused   = 1'b1;
          next_st        = BSX_IDLE;
          next_cmd_ready = 1'b1;
        end
      end
    end
    else if (cyc.done)
    begin
      next_issued = 1'b0;
      next_bits   = bits + 4'h1;
      unique case (st)
        BSX_RST_R1: next_st = BSX_RST_W0;
        BSX_RST_W0: next_st = BSX_RST_R2;
        BSX_RST_R2:
        begin
          next_bits = CNT_RESET;
          next_st   = (op == BSX_CMD_RESET) ? BSX_IDLE : BSX_ADDR;
        end
        BSX_ADDR:
        begin
          next_sh = {sh[14:0], 1'b0};
          if (bits == 4'(ADDR_BITS - 1))
          begin
            next_bits = CNT_RESET;
            if (op == BSX_CMD_WRITE)
            begin
              next_sh[15:8] = wr_data;
              next_wr_take  = 1'b1;
              next_st       = BSX_WBYTE;
            end
            else
              next_st = BSX_RBYTE;
          end
        end
        BSX_RBYTE:
        begin
          next_sh[7:0] = {sh[6:0], cyc.rbit};
          if (bits == 4'(BYTE_BITS - 1))
          begin
            next_bits     = CNT_RESET;
            next_rd_valid = 1'b1;
            next_rd_data  = {sh[6:0], cyc.rbit};
            next_left     = left - 6'h1;
            next_st       = (left <= 6'h1) ? BSX_RSTOP : BSX_RBYTE;
          end
        end
        BSX_WBYTE:
        begin
          next_sh = {sh[14:0], 1'b0};
          if (bits == 4'(BYTE_BITS - 1))
          begin
            next_bits = CNT_RESET;
            next_left = left - 6'h1;
            if (left > 6'h1 && wr_valid)
            begin
              next_sh[15:8] = wr_data;
              next_wr_take  = 1'b1;
            end
            else
              next_st = BSX_GO_R;
          end
        end
        BSX_GO_R:   next_st = BSX_GO_W1;
        BSX_GO_W1:  next_st = BSX_GO_R2;
        BSX_GO_R2:
        begin
          next_busy_nv = 1'b1;
          next_st      = BSX_IDLE;
        end
        BSX_POLL:
        begin
          next_busy_nv = !cyc.rbit;
          next_st      = BSX_IDLE;
        end
        BSX_RSTOP:  next_st = BSX_IDLE;
        default:    next_st = BSX_IDLE;
      endcase
    end
    // guard falling during a control register load or the start sequence's read and write 1 aborts it before the closing read
    // a fall between pin cycles is held by the level, so it is seen at the next cycle end
    if (op == BSX_CMD_WRITE && ctrl_wr && (st == BSX_WBYTE || st == BSX_GO_R || st == BSX_GO_W1)
        && cyc.done && guarded(gsync[1], guard_pin_honor_bit))
    begin
      next_st      = BSX_RST_R1;
      next_op      = BSX_CMD_RESET;
      next_refused = 1'b1;
      next_wr_take = 1'b0;
    end
  end

  // controller registers
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      st        <= BSX_IDLE;
      op        <= BSX_CMD_RESET;
      ctrl_wr   <= 1'b0;
      sh        <= ADDR_WRAP;
      bits      <= CNT_RESET;
      left      <= 6'h00;
      issued    <= 1'b0;
      cmd_ready <= 1'b0;
      wr_take   <= 1'b0;
      rd_valid  <= 1'b0;
      rd_data   <= DATA_RESET;
      busy_nv   <= 1'b0;
      refused   <= 1'b0;
    end
    else
    begin
      st        <= next_st;
      op        <= next_op;
      ctrl_wr   <= next_ctrl_wr;
      sh        <= next_sh;
      bits      <= next_bits;
      left      <= next_left;
      issued    <= next_issued;
      cmd_ready <= next_cmd_ready;
      wr_take   <= next_wr_take;
      rd_valid  <= next_rd_valid;
      rd_data   <= next_rd_data;
      busy_nv   <= next_busy_nv;
      refused   <= next_refused;
    end
  end
endmodule // bsx_host

/* sim/bsx_properties.sv */
// bsx_properties: pin and handshake checks on the bsx_host ports
// assumes it is bound onto bsx_host, one mclk domain, synchronous active-low reset
`timescale 1ns/10ps
module bsx_properties
  import bsx_pkg::*;
#(
  parameter int unsigned STROBE = STROBE_CYC
)(
  input wire logic          mclk,
  input wire logic          reset_n,
  input wire logic          cmd_valid,
  input bsx_pkg::bsx_cmd_t  cmd,
  input wire logic [15:0]   cmd_addr,
  input wire logic          guard_pin_n,
  input wire logic          guard_pin_honor_bit,
  input wire logic          cmd_ready,
  input wire logic          refused,
  input wire logic          sio_out,
  input wire logic          sio_oe_n,
  input wire logic          ce_n,
  input wire logic          oe_n,
  input wire logic          we_n
);
  import bsx_pkg::*;
  logic [3:0] lo_cnt;
  logic [3:0] next_lo_cnt;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // length of the current chip-select strobe
  always_comb next_lo_cnt = ce_n ? 4'h0 : lo_cnt + 4'h1;
  always_ff @(posedge mclk) lo_cnt <= reset_n ? next_lo_cnt : 4'h0;
  // command steps
  sequence s_take_rw;
    cmd_valid && cmd_ready && (cmd == BSX_CMD_READ || cmd == BSX_CMD_WRITE);
  endsequence
  sequence s_ctrl_wr;
    cmd_valid && cmd_ready && cmd == BSX_CMD_WRITE && cmd_addr == CTRL_ADDR;
  endsequence
  // the host sees the guard pin through two flip-flops
  sequence s_guarded;
    s_ctrl_wr ##0 (guard_pin_honor_bit && !$past(guard_pin_n, 2));
  endsequence
  property p_no_we_oe; !ce_n |-> we_n || oe_n; endproperty
  a_no_we_oe: assert property (p_no_we_oe) else $error("write and output enable low together");
  property p_oe_float; !oe_n |-> sio_oe_n; endproperty
  a_oe_float: assert property (p_oe_float) else $error("host drives data during a read");
  property p_ce_float; $rose(ce_n) |=> sio_oe_n; endproperty
  a_ce_float: assert property (p_ce_float) else $error("data line held after deselect");
  property p_we_drive; !we_n |-> !sio_oe_n; endproperty
  a_we_drive: assert property (p_we_drive) else $error("write cycle without data driven");
  property p_we_ce; $rose(we_n) |-> $rose(ce_n); endproperty
  a_we_ce: assert property (p_we_ce) else $error("write strobe ends apart from chip enable");
  property p_strobe; $rose(ce_n) |-> lo_cnt == STROBE; endproperty
  a_strobe: assert property (p_strobe) else $error("strobe length wrong");
  property p_sio_hold; !we_n && $past(!we_n) |-> $stable(sio_out); endproperty
  a_sio_hold: assert property (p_sio_hold) else $error("data bit moved in a write strobe");
  property p_first_rd; s_take_rw |=> we_n until (!oe_n && !ce_n); endproperty
  a_first_rd: assert property (p_first_rd) else $error("sequence not opened by a read");
  property p_first_soon;
    s_take_rw ##0 !(cmd == BSX_CMD_WRITE && cmd_addr == CTRL_ADDR && guard_pin_honor_bit && !$past(guard_pin_n, 2))
      |-> ##[1:10] (!oe_n && !ce_n);
  endproperty
  a_first_soon: assert property (p_first_soon) else $error("first read cycle late");
  property p_guard_ref; s_guarded |-> ##[1:6] refused; endproperty
  a_guard_ref: assert property (p_guard_ref) else $error("guarded control write not refused");
  property p_guard_quiet; s_guarded |=> ce_n [*8]; endproperty
  a_guard_quiet: assert property (p_guard_quiet) else $error("pins active on refused write");
  property p_honor_off; s_ctrl_wr ##0 !guard_pin_honor_bit |=> !refused [*8]; endproperty
  a_honor_off: assert property (p_honor_off) else $error("guard honoured with honor bit clear");
endmodule // bsx_properties

/* sim/bsx_eeprom_model.sv */
// bsx_eeprom_model: behavioural bit-serial eeprom seen from its pins
// assumes strobes last whole mclk cycles and chip enable rises with the others
`timescale 1ns/10ps
module bsx_eeprom_model #(
  parameter int NV_CYC = 300
)(
  input  wire logic mclk,
  input  wire logic ce_n,
  input  wire logic oe_n,
  input  wire logic we_n,
  input  wire logic sio,
  input  wire logic guard_n,
  input  wire logic honor,
  output logic      dev_en,
  output logic      dev_bit
);
  logic [15:0] addr;
  logic [7:0]  mem_byte;
  logic [3:0]  cnt;
  logic [2:0]  mode;
  logic        ce_q, we_q, wel;
  logic [1:0]  rd_run;  // reads in a row since the last write, saturating at 2
  int          busy;
  // array content is a fixed function of the address
  assign mem_byte = addr[7:0] ^ addr[15:8] ^ 8'h5a;
  // output only while chip and output enable are low
  assign dev_en = !ce_n && !oe_n;
  // low during a nonvolatile write, array data in a read, high otherwise
  assign dev_bit = busy > 0 ? 1'b0 : (mode == 3'h2 || mode == 3'h3) ? mem_byte[~cnt[2:0]] : 1'b1;
  initial
  begin
    {mode, cnt, addr, busy, rd_run} = '0;
    {ce_q, we_q, wel} = 3'h6;
  end
  // cycle decoder: a bit is taken as chip enable rises
  always @(posedge mclk)
  begin
    ce_q <= ce_n;
    we_q <= we_n;
    if (busy > 0) busy <= busy - 1;
    if (!guard_n && honor) wel <= 1'b0;
    if (ce_n && !ce_q)
    begin
      rd_run <= we_q ? ((rd_run == 2'h2) ? 2'h2 : rd_run + 2'h1) : 2'h0;
      // a 0 right after the closing read of a reset is the first address bit
      if (!we_q && rd_run != 2'h0 && !sio && busy == 0
          && !(mode == 3'h1 && cnt == 4'h0 && rd_run == 2'h1))
      begin
        mode <= 3'h1;
        cnt <= 4'h0;
        wel <= 1'b1;
      end
      else if (!we_q)
        case (mode)
          3'h1:
          begin
            addr <= {addr[14:0], sio};
            cnt <= cnt + 4'h1;
            if (cnt == 4'hf) mode <= 3'h2;
          end
          3'h2, 3'h4: mode <= 3'h4;
          3'h3: mode <= sio ? 3'h0 : 3'h3;
          3'h5: mode <= sio ? 3'h6 : 3'h0;
          default: mode <= 3'h0;
        endcase
      else
        case (mode)
          3'h2, 3'h3:
          begin
            mode <= 3'h3;
            cnt <= {1'b0, cnt[2:0] + 3'h1};
            if (cnt[2:0] == 3'h7) addr <= addr + 16'h0001;
          end
          3'h4: mode <= 3'h5;
          3'h6:
          begin
            if (wel && !(addr == 16'hffff && !guard_n && honor)) busy <= NV_CYC;
            wel <= 1'b0;
            mode <= 3'h0;
          end
          default: mode <= mode;
        endcase
    end
  end
endmodule // bsx_eeprom_model

/* sim/bit_serial_bus_eeprom_access_test.sv */
// bit_serial_bus_eeprom_access_test: self-checking bench for bsx_host
// assumes bsx_eeprom_model as the device and bsx_properties bound on bsx_host
`timescale 1ns/10ps
module bit_serial_bus_eeprom_access_test;
  import bsx_pkg::*;
  logic       mclk, reset_n, cmd_valid, wr_valid, guard_pin_n, honor, sio_in, float_bit;
  logic       cmd_ready, wr_take, rd_valid, busy_nv, refused, sio_out, sio_oe_n;
  logic       ce_n, oe_n, we_n, dev_en, dev_bit, seen_ref;
  bsx_cmd_t   cmd;
  logic [15:0] cmd_addr;
  logic [5:0] cmd_len;
  logic [7:0] wr_data, rd_data;
  logic [7:0] rd_q[$];
  int         failures, tests_run, n_take;
  // clock
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // shared data line: host, device, or a changing level when nobody drives
  assign sio_in = !sio_oe_n ? sio_out : (dev_en ? dev_bit : float_bit);
  always @(posedge mclk) float_bit <= ~sio_in;
  always @(posedge mclk) if (wr_take === 1'b1) wr_data <= wr_data + 8'h11;
  bsx_host #(.STROBE(2)) DUT (.mclk(mclk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_addr(cmd_addr), .cmd_len(cmd_len), .wr_valid(wr_valid), .wr_data(wr_data),
    .guard_pin_n(guard_pin_n), .guard_pin_honor_bit(honor), .sio_in(sio_in), .cmd_ready(cmd_ready),
    .wr_take(wr_take), .rd_valid(rd_valid), .rd_data(rd_data), .busy_nv(busy_nv), .refused(refused),
    .sio_out(sio_out), .sio_oe_n(sio_oe_n), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n));
  bsx_eeprom_model #(.NV_CYC(300)) u_dev (.mclk(mclk), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .sio(sio_in), .guard_n(guard_pin_n), .honor(honor), .dev_en(dev_en), .dev_bit(dev_bit));
  function automatic logic [7:0] exp_byte(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // one command through the user port, collecting what comes back
  task automatic run(input bsx_cmd_t c, input logic [15:0] a, input logic [5:0] l);
    int k;
    n_take = 0;
    seen_ref = 1'b0;
    rd_q.delete();
    while (cmd_ready !== 1'b1)
    begin
      @(posedge mclk);
      #1;
    end
    {cmd, cmd_addr, cmd_len, cmd_valid} = {c, a, l, 1'b1};
    @(posedge mclk);
    #1;
    cmd_valid = 1'b0;
    for (k = 0; k < 4000; k++)
    begin
      if (rd_valid === 1'b1) rd_q.push_back(rd_data);
      if (wr_take === 1'b1) n_take++;
      if (refused === 1'b1) seen_ref = 1'b1;
      if (cmd_ready === 1'b1 && k > 1) break;
      @(posedge mclk);
      #1;
    end
    if (k == 4000) failures++;
  endtask
  task automatic read_check(input logic [15:0] a, input logic [5:0] l);
    run(BSX_CMD_READ, a, l);
    check(16'(rd_q.size()), {10'h000, l});
    foreach (rd_q[i]) check({8'h00, rd_q[i]}, {8'h00, exp_byte(a + 16'(i))});
  endtask
  task automatic wait_nv;
    int k;
    for (k = 0; k < 60 && busy_nv !== 1'b0; k++) run(BSX_CMD_POLL, 16'h0000, 6'h00);
    check({15'h0000, busy_nv}, 16'h0000);
  endtask
  task automatic t_reads;
    read_check(16'h1234, 6'h03);
    read_check(16'hffff, 6'h02);
    $display("test reads finished");
  endtask
  task automatic t_reset;
    run(BSX_CMD_RESET, 16'h0000, 6'h00);
    run(BSX_CMD_POLL, 16'h0000, 6'h00);
    check({15'h0000, busy_nv}, 16'h0000);
    $display("test reset finished");
  endtask
  task automatic t_write;
    run(BSX_CMD_WRITE, 16'h0040, 6'h02);
    check(16'(n_take), 16'h0002);
    check({15'h0000, busy_nv}, 16'h0001);
    run(BSX_CMD_POLL, 16'h0000, 6'h00);
    check({15'h0000, busy_nv}, 16'h0001);
    wait_nv();
    $display("test write finished");
  endtask
  task automatic t_guard;
    {guard_pin_n, honor} = 2'b01;
    repeat (3) @(posedge mclk);
    #1;
    run(BSX_CMD_WRITE, CTRL_ADDR, 6'h01);
    check({15'h0000, seen_ref}, 16'h0001);
    check(16'(n_take), 16'h0000);
    read_check(16'h0100, 6'h01);
    honor = 1'b0;
    run(BSX_CMD_WRITE, CTRL_ADDR, 6'h01);
    check({14'h0000, seen_ref, busy_nv}, 16'h0001);
    wait_nv();
    guard_pin_n = 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    $display("test guard finished");
  endtask
  task automatic t_abort;
    honor = 1'b1;
    fork
      run(BSX_CMD_WRITE, CTRL_ADDR, 6'h01);
      begin
        @(posedge wr_take);
        #1;
        guard_pin_n = 1'b0;
      end
    join
    check({14'h0000, seen_ref, busy_nv}, 16'h0002);
    {guard_pin_n, honor} = 2'b10;
    read_check(16'h0200, 6'h01);
    $display("test abort finished");
  endtask
  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // main sequence
  initial
  begin
    {reset_n, cmd_valid, cmd, cmd_addr, cmd_len} = '0;
    {wr_valid, wr_data, guard_pin_n, honor, float_bit} = {1'b1, 8'ha5, 3'b100};
    {failures, tests_run} = '0;
    repeat (4) @(posedge mclk);
    #1;
    reset_n = 1'b1;
    t_reads();
    t_reset();
    t_write();
    t_guard();
    t_abort();
    conclude();
  end
  // watchdog
  initial
  begin
    repeat (40000) @(posedge mclk);
    failures++;
    conclude();
  end
endmodule // bit_serial_bus_eeprom_access_test
bind bsx_host bsx_properties #(.STROBE(STROBE)) u_props (.mclk(mclk), .reset_n(reset_n),
  .cmd_valid(cmd_valid), .cmd(cmd), .cmd_addr(cmd_addr), .guard_pin_n(guard_pin_n),
  .guard_pin_honor_bit(guard_pin_honor_bit), .cmd_ready(cmd_ready), .refused(refused),
  .sio_out(sio_out), .sio_oe_n(sio_oe_n), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n));
